// ### verilog/sos_top.sv
// System oscillator select: source models, glitch-free switch and register slave
// How it works
// - Watchdog and time base ticks come from the same oscillators as the system clock.
// - Five sources: crystal, external RC, outside clock, internal fast RC, slow RC.
// - Internal fast RC runs at 910kHz, 2MHz, 4MHz or 8MHz by configuration.
// - Internal slow RC gives a 32kHz tick with no outside parts.
// - Software picks slow or fast and the divide ratio at run time.
// - Static options, caught after reset, choose the physical fast source.
// - Every option code maps to one fast source; the slow source is fixed.
// - Crystal mode uses both clock pins, driving pin b as feedback.
// - External RC uses pin a only; pin b stays ordinary port C I/O.
// - Outside clock enters on pin a, filtered unless filtering is turned off.
// - Internal fast RC frees both clock pins as ordinary port C I/O.
// - Choice low: divider 000/001 slow, 010..111 fast divided 64 down to 2.
// - Running from the slow source stops the fast oscillator and its taps.
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "sos_params.svh"
module sos_top import sos_pkg::*; (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [1:0]  cfg_fast_src,
  input  wire logic [1:0]  cfg_int_fast_freq,
  input  wire logic        cfg_filter_off,
  input  wire logic        clock_pin_a_in,
  output logic             clock_pin_a_out,
  output logic             clock_pin_a_oe,
  input  wire logic        clock_pin_b_in,
  output logic             clock_pin_b_out,
  output logic             clock_pin_b_oe,
  input  wire logic        port_c_bit0_out,
  input  wire logic        port_c_bit0_oe,
  input  wire logic        port_c_bit1_out,
  input  wire logic        port_c_bit1_oe,
  output logic      [1:0]  port_c_free,
  output logic             sys_tick,
  output logic             fast_tick,
  output logic             wdt_tick,
  output logic             tbc_tick,
  output logic             fast_osc_running
);

  // =====================================================================
  // Oscillator increments, derived from the clock rate
  localparam logic [63:0] INC_910K_W = (64'(`SOS_FAST_910K_HZ) << 32) / 64'(`SOS_CLK_HZ);
  localparam logic [63:0] INC_2M_W   = (64'(`SOS_FAST_2M_HZ) << 32) / 64'(`SOS_CLK_HZ);
  localparam logic [63:0] INC_4M_W   = (64'(`SOS_FAST_4M_HZ) << 32) / 64'(`SOS_CLK_HZ);
  localparam logic [63:0] INC_8M_W   = (64'(`SOS_FAST_8M_HZ) << 32) / 64'(`SOS_CLK_HZ);
  localparam logic [63:0] INC_SLOW_W = (64'(`SOS_SLOW_HZ) << 32) / 64'(`SOS_CLK_HZ);

  // =====================================================================
  // Declarations
  sos_fast_src_type src_reg;
  sos_fast_src_type src_next;
  logic [1:0]       freq_reg;
  logic [1:0]       freq_next;
  logic             filt_off_reg;
  logic             filt_off_next;
  logic             cfg_taken_reg;
  logic             cfg_taken_next;

  logic [2:0]       samp_reg;
  logic [2:0]       samp_next;
  logic             filt_reg;
  logic             filt_next;
  logic             prev_reg;
  logic             prev_next;
  logic             pin_level;
  logic             pin_tick;
  logic             internal_fast_rc_tick;
  logic             slow_tick;
  logic [31:0]      internal_fast_rc_incr;
  logic             raw_fast_tick;
  logic [6:0]       tap;

  logic [2:0]       div_reg;
  logic [2:0]       div_next;
  logic             choice_reg;
  logic             choice_next;
  logic             tgt_slow;
  logic [2:0]       tgt_exp;

  sos_sw_state_type state_reg;
  sos_sw_state_type state_next;
  logic             act_slow_reg;
  logic             act_slow_next;
  logic [2:0]       act_exp_reg;
  logic [2:0]       act_exp_next;
  logic             cur_tick;
  logic             fast_run_reg;
  logic             fast_run_next;

  logic             sys_tick_reg;
  logic             sys_tick_next;
  logic             fast_tick_reg;
  logic             fast_tick_next;
  logic             wdt_tick_reg;
  logic             wdt_tick_next;
  logic             tbc_tick_reg;
  logic             tbc_tick_next;

  logic             a_out_reg;
  logic             a_out_next;
  logic             a_oe_reg;
  logic             a_oe_next;
  logic             b_out_reg;
  logic             b_out_next;
  logic             b_oe_reg;
  logic             b_oe_next;
  logic [1:0]       free_reg;
  logic [1:0]       free_next;

  logic             wait_reg;
  logic             wait_next;
  logic             ack_reg;
  logic             ack_next;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;
  logic             req;

  // =====================================================================
  // Static options are caught on the first edge after reset release
  always_comb begin
    cfg_taken_next = 1'b1;
    src_next       = src_reg;
    freq_next      = freq_reg;
    filt_off_next  = filt_off_reg;
    if (!cfg_taken_reg) begin
      src_next      = sos_fast_src_type'(cfg_fast_src);
      freq_next     = cfg_int_fast_freq;
      filt_off_next = cfg_filter_off;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_taken_reg <= 1'b0;
      src_reg       <= SOS_SRC_CRYSTAL;
      freq_reg      <= 2'h0;
      filt_off_reg  <= 1'b0;
    end else begin
      cfg_taken_reg <= cfg_taken_next;
      src_reg       <= src_next;
      freq_reg      <= freq_next;
      filt_off_reg  <= filt_off_next;
    end
  end

  // =====================================================================
  // Pin a edge detector; the three-sample filter costs three cycles of lag
  always_comb begin
    samp_next = {samp_reg[1:0], clock_pin_a_in};
    filt_next = filt_reg;
    if (samp_reg == 3'h7) begin
      filt_next = 1'b1;
    end else if (samp_reg == 3'h0) begin
      filt_next = 1'b0;
    end
    pin_level = (src_reg == SOS_SRC_OUTSIDE && !filt_off_reg) ? filt_reg : samp_reg[0];
    prev_next = pin_level;
    pin_tick  = pin_level & ~prev_reg & fast_run_reg & cfg_taken_reg
                & (src_reg != SOS_SRC_INT_FAST);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      samp_reg <= 3'h0;
      filt_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      samp_reg <= samp_next;
      filt_reg <= filt_next;
      prev_reg <= prev_next;
    end
  end

  // Internal fast RC frequency pick
  always_comb begin
    case (freq_reg)
      2'h0:    internal_fast_rc_incr = INC_910K_W[31:0];
      2'h1:    internal_fast_rc_incr = INC_2M_W[31:0];
      2'h2:    internal_fast_rc_incr = INC_4M_W[31:0];
      default: internal_fast_rc_incr = INC_8M_W[31:0];
    endcase
  end

  sos_tick_gen u_fast_rc (
    .clk    (clk),
    .resetn (resetn),
    .enable (fast_run_reg & cfg_taken_reg & (src_reg == SOS_SRC_INT_FAST)),
    .incr   (internal_fast_rc_incr),
    .tick   (internal_fast_rc_tick)
  );

  // Slow RC always runs, it keeps the watchdog alive
  sos_tick_gen u_slow_rc (
    .clk    (clk),
    .resetn (resetn),
    .enable (1'b1),
    .incr   (INC_SLOW_W[31:0]),
    .tick   (slow_tick)
  );

  assign raw_fast_tick = (src_reg == SOS_SRC_INT_FAST) ? internal_fast_rc_tick : pin_tick;

  sos_prescaler u_prescaler (
    .clk       (clk),
    .resetn    (resetn),
    .run       (fast_run_reg),
    .fast_tick (raw_fast_tick),
    .tap       (tap)
  );

  // =====================================================================
  // Target source from the mode register
  always_comb begin
    tgt_slow = !choice_reg && (div_reg < `SOS_DIV_FIRST_FAST);
    tgt_exp  = 3'h0;
    if (!choice_reg && !tgt_slow) begin
      tgt_exp = 3'(`SOS_DIV_EXP_BASE - {1'b0, div_reg});
    end
  end

  // =====================================================================
  // Switch-over sequencer: old tick ends the old clock, new tick starts it
  always_comb begin
    state_next    = state_reg;
    act_slow_next = act_slow_reg;
    act_exp_next  = act_exp_reg;
    cur_tick      = act_slow_reg ? slow_tick : tap[act_exp_reg];
    case (state_reg)
      SOS_SW_RUN: begin
        if (tgt_slow != act_slow_reg || (!tgt_slow && tgt_exp != act_exp_reg)) begin
          state_next = SOS_SW_DRAIN;
        end
      end
      SOS_SW_DRAIN: begin
        if (cur_tick) begin
          act_slow_next = tgt_slow;
          act_exp_next  = tgt_exp;
          state_next    = SOS_SW_WAIT;
        end
      end
      SOS_SW_WAIT: begin
        if (cur_tick) begin
          state_next = SOS_SW_RUN;
        end
      end
      default: begin
        state_next = SOS_SW_RUN;
      end
    endcase
    // Fast stops only once slow is active and still wanted
    fast_run_next  = !(act_slow_next && tgt_slow);
    sys_tick_next  = cur_tick && (state_reg != SOS_SW_WAIT);
    fast_tick_next = tap[0];
    wdt_tick_next  = slow_tick;
    tbc_tick_next  = fast_run_reg ? tap[0] : slow_tick;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg     <= SOS_SW_RUN;
      act_slow_reg  <= 1'b0;
      act_exp_reg   <= 3'h0;
      fast_run_reg  <= 1'b1;
      sys_tick_reg  <= 1'b0;
      fast_tick_reg <= 1'b0;
      wdt_tick_reg  <= 1'b0;
      tbc_tick_reg  <= 1'b0;
    end else begin
      state_reg     <= state_next;
      act_slow_reg  <= act_slow_next;
      act_exp_reg   <= act_exp_next;
      fast_run_reg  <= fast_run_next;
      sys_tick_reg  <= sys_tick_next;
      fast_tick_reg <= fast_tick_next;
      wdt_tick_reg  <= wdt_tick_next;
      tbc_tick_reg  <= tbc_tick_next;
    end
  end

  // =====================================================================
  // Clock pin and shared port C ownership
  always_comb begin
    a_out_next = port_c_bit0_out;
    a_oe_next  = port_c_bit0_oe;
    b_out_next = port_c_bit1_out;
    b_oe_next  = port_c_bit1_oe;
    free_next  = 2'h3;
    case (src_reg)
      SOS_SRC_CRYSTAL: begin
        a_oe_next  = 1'b0;
        a_out_next = 1'b0;
        b_oe_next  = 1'b1;
        b_out_next = ~clock_pin_a_in & fast_run_reg;  // Inverting feedback, held low when stopped
        free_next  = 2'h0;
      end
      SOS_SRC_RC_EXT: begin
        a_oe_next  = 1'b0;
        a_out_next = 1'b0;
        free_next  = 2'h2;
      end
      SOS_SRC_OUTSIDE: begin
        a_oe_next  = 1'b0;
        a_out_next = 1'b0;
        b_oe_next  = 1'b0;
        b_out_next = 1'b0;
        free_next  = 2'h0;
      end
      default: begin
        free_next = 2'h3;
      end
    endcase
    if (!cfg_taken_reg) begin
      a_oe_next = 1'b0;                        // Pins stay quiet until options are known
      b_oe_next = 1'b0;
      free_next = 2'h0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      a_out_reg <= 1'b0;
      a_oe_reg  <= 1'b0;
      b_out_reg <= 1'b0;
      b_oe_reg  <= 1'b0;
      free_reg  <= 2'h0;
    end else begin
      a_out_reg <= a_out_next;
      a_oe_reg  <= a_oe_next;
      b_out_reg <= b_out_next;
      b_oe_reg  <= b_oe_next;
      free_reg  <= free_next;
    end
  end

  // =====================================================================
  // Avalon-MM slave: one wait cycle, then waitrequest low for one cycle
  always_comb begin
    req         = avs_read | avs_write;
    wait_next   = 1'b1;
    ack_next    = 1'b0;
    rdata_next  = rdata_reg;
    div_next    = div_reg;
    choice_next = choice_reg;
    if (req && wait_reg && !ack_reg) begin
      wait_next  = 1'b0;
      ack_next   = 1'b1;
      rdata_next = 32'h00000000;               // Unmapped offsets read zero
      case (avs_address)
        `SOS_OFS_MODE: begin
          rdata_next[`SOS_MODE_DIV_MSB:`SOS_MODE_DIV_LSB] = div_reg;
          rdata_next[`SOS_MODE_CHOICE] = choice_reg;
        end
        `SOS_OFS_STATUS: begin
          rdata_next[7:0] = {clock_pin_b_in, samp_reg[0], fast_run_reg,
                             (state_reg != SOS_SW_RUN), act_exp_reg, act_slow_reg};
        end
        `SOS_OFS_CONFIG: begin
          rdata_next[4:0] = {filt_off_reg, freq_reg, src_reg};
        end
        default: begin
          rdata_next = 32'h00000000;
        end
      endcase
    end
    // Write lands on the edge that sees waitrequest low
    if (avs_write && !wait_reg && avs_byteenable[0] && avs_address == `SOS_OFS_MODE) begin
      div_next    = avs_writedata[`SOS_MODE_DIV_MSB:`SOS_MODE_DIV_LSB];
      choice_next = avs_writedata[`SOS_MODE_CHOICE];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_reg   <= 1'b1;
      ack_reg    <= 1'b0;
      rdata_reg  <= 32'h00000000;
      div_reg    <= 3'(`SOS_MODE_RESET >> `SOS_MODE_DIV_LSB);
      choice_reg <= 1'(`SOS_MODE_RESET >> `SOS_MODE_CHOICE);
    end else begin
      wait_reg   <= wait_next;
      ack_reg    <= ack_next;
      rdata_reg  <= rdata_next;
      div_reg    <= div_next;
      choice_reg <= choice_next;
    end
  end

  // =====================================================================
  // Outputs straight from flip-flops
  assign avs_readdata     = rdata_reg;
  assign avs_waitrequest  = wait_reg;
  assign clock_pin_a_out  = a_out_reg;
  assign clock_pin_a_oe   = a_oe_reg;
  assign clock_pin_b_out  = b_out_reg;
  assign clock_pin_b_oe   = b_oe_reg;
  assign port_c_free      = free_reg;
  assign sys_tick         = sys_tick_reg;
  assign fast_tick        = fast_tick_reg;
  assign wdt_tick         = wdt_tick_reg;
  assign tbc_tick         = tbc_tick_reg;
  assign fast_osc_running = fast_run_reg;

endmodule

// ### verilog/sos_params.svh
// Offsets, field positions, reset values and timing figures of the oscillator select block
`ifndef SOS_PARAMS_SVH
`define SOS_PARAMS_SVH

// =====================================================================
// Register byte offsets on the Avalon-MM slave
`define SOS_OFS_MODE       4'h0
`define SOS_OFS_STATUS     4'h4
`define SOS_OFS_CONFIG     4'h8

// =====================================================================
// Field positions in system_mode_reg
`define SOS_MODE_DIV_MSB   7
`define SOS_MODE_DIV_LSB   5
`define SOS_MODE_CHOICE    0
`define SOS_MODE_RESET     8'h01

// Divider codes below this value pick the slow source
`define SOS_DIV_FIRST_FAST 3'h2
// Divide exponent is this figure minus the divider code
`define SOS_DIV_EXP_BASE   4'h8

// =====================================================================
// Timing figures in Hz
`define SOS_CLK_HZ         40000000
`define SOS_FAST_910K_HZ   910000
`define SOS_FAST_2M_HZ     2000000
`define SOS_FAST_4M_HZ     4000000
`define SOS_FAST_8M_HZ     8000000
`define SOS_SLOW_HZ        32000

`endif

// ### verilog/sos_pkg.sv
// Types shared by the oscillator select block
package sos_pkg;

  // =====================================================================
  // Static choice of the physical fast oscillator, in configuration order
  typedef enum logic [1:0] {
    SOS_SRC_CRYSTAL,
    SOS_SRC_RC_EXT,
    SOS_SRC_OUTSIDE,
    SOS_SRC_INT_FAST
  } sos_fast_src_type;

  // Switch-over sequencer states
  typedef enum logic [1:0] {
    SOS_SW_RUN,
    SOS_SW_DRAIN,
    SOS_SW_WAIT
  } sos_sw_state_type;

endpackage

// ### verilog/sos_tick_gen.sv
// Phase accumulator that models an internal RC oscillator as a clock-enable tick
`timescale 1ns/1ps
module sos_tick_gen (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        enable,
  input  wire logic [31:0] incr,
  output logic             tick
);

  logic [31:0] acc_reg;
  logic [31:0] acc_next;
  logic        tick_reg;
  logic        tick_next;
  logic [32:0] sum;

  // =====================================================================
  // Carry out of the accumulator marks one oscillator period
  always_comb begin
    sum       = {1'b0, acc_reg} + {1'b0, incr};
    acc_next  = enable ? sum[31:0] : 32'h00000000;  // Stopped oscillator restarts at phase 0
    tick_next = enable & sum[32];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_reg  <= 32'h00000000;
      tick_reg <= 1'b0;
    end else begin
      acc_reg  <= acc_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule

// ### verilog/sos_prescaler.sv
// Common prescaler on the fast source giving the divided taps
`timescale 1ns/1ps
module sos_prescaler (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       run,
  input  wire logic       fast_tick,
  output logic      [6:0] tap
);

  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic [6:0] tap_reg;
  logic [6:0] tap_next;

  // =====================================================================
  // One counter feeds every tap, so all taps stay phase aligned
  always_comb begin
    cnt_next = cnt_reg;
    if (!run) begin
      cnt_next = 6'h00;
    end else if (fast_tick) begin
      cnt_next = cnt_reg + 6'h01;
    end
  end

  // Tap e fires on every 2^e-th fast tick
  for (genvar e = 0; e < 7; e++) begin : g_tap
    localparam logic [5:0] MASK = 6'((7'h01 << e) - 7'h01);
    assign tap_next[e] = run & fast_tick & ((cnt_reg & MASK) == MASK);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 6'h00;
      tap_reg <= 7'h00;
    end else begin
      cnt_reg <= cnt_next;
      tap_reg <= tap_next;
    end
  end

  assign tap = tap_reg;

endmodule

// ### bench/sos_top_sva.sv
// Port checker for the oscillator select block
`timescale 1ns/1ps
// =====================================================================
// Checker
module sos_chk (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        port_c_bit0_out,
  input wire logic        port_c_bit0_oe,
  input wire logic        clock_pin_a_out,
  input wire logic        clock_pin_a_oe,
  input wire logic        clock_pin_a_in,
  input wire logic        clock_pin_b_out,
  input wire logic        clock_pin_b_oe,
  input wire logic [1:0]  port_c_free,
  input wire logic        sys_tick,
  input wire logic        fast_tick,
  input wire logic        wdt_tick,
  input wire logic        tbc_tick,
  input wire logic        fast_osc_running
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Bus answers after exactly one wait cycle and acks for one cycle only
  chk_ack_after_one: assert property ((avs_read || avs_write) && avs_waitrequest
    && $past(avs_waitrequest) |=> !avs_waitrequest) else $error("request not acked");
  chk_ack_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("ack longer than one cycle");
  // Read data may only move together with an ack
  chk_rdata_hold: assert property ($changed(avs_readdata) |-> !avs_waitrequest)
    else $error("read data moved without ack");
  // A stopped fast oscillator gives no taps
  chk_fast_quiet: assert property (!fast_osc_running && $past(!fast_osc_running)
    |-> !fast_tick) else $error("fast tick while stopped");
  // No runt pulses: ticks are never back to back
  chk_sys_no_runt: assert property (sys_tick |=> !sys_tick)
    else $error("system tick runt");
  chk_slow_period: assert property (wdt_tick |=> !wdt_tick [*8])
    else $error("slow tick too fast");
  chk_tbc_follow: assert property (fast_osc_running && $past(fast_osc_running)
    |-> tbc_tick == fast_tick) else $error("time base not on fast source");
  // With the fast side stopped the time base must fall back to the slow ticks
  chk_tbc_slow: assert property (!fast_osc_running && $past(!fast_osc_running)
    |-> tbc_tick == wdt_tick) else $error("time base not on slow source");
  // Freed pin a carries the port wishes; pin a is never freed alone
  chk_pin_a_gpio: assert property (port_c_free[0] && $past(port_c_free[0])
    |-> clock_pin_a_oe == $past(port_c_bit0_oe) && clock_pin_a_out == $past(port_c_bit0_out))
    else $error("pin a not passed to port");
  chk_crystal_b: assert property (clock_pin_b_oe && !port_c_free[1]
    |-> !clock_pin_a_oe && port_c_free == 2'b00) else $error("pin use wrong in crystal mode");
  // Crystal feedback on pin b is the inverse of pin a, low while stopped
  chk_crystal_fb: assert property (clock_pin_b_oe && !port_c_free[1] |=>
    clock_pin_b_out == (!$past(clock_pin_a_in) && $past(fast_osc_running)))
    else $error("crystal feedback wrong");
endmodule

bind sos_top sos_chk chk_i (.clk, .resetn, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .port_c_bit0_out, .port_c_bit0_oe, .clock_pin_a_out, .clock_pin_a_oe,
  .clock_pin_b_oe, .port_c_free, .sys_tick, .fast_tick, .wdt_tick, .tbc_tick,
  .fast_osc_running, .clock_pin_a_in, .clock_pin_b_out);

// ### bench/sos_osc_model.sv
// Outside oscillator part: crystal, RC network or clock source on the clock pins
`timescale 1ns/1ps
module sos_osc_model (
  input  wire logic       clk,
  input  wire logic       en,
  input  wire logic [3:0] half,
  output logic            pin_a,
  output logic            pin_b
);
  logic [3:0] cnt;
  initial begin
    cnt = 4'h0;
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // Pin a swings only while powered; a floating pin b changes every cycle
  always @(posedge clk) begin
    pin_b <= ~pin_b;
    if (!en) begin
      cnt <= 4'h0;
      pin_a <= 1'b0;
    end else if (cnt >= half - 4'h1) begin
      cnt <= 4'h0;
      pin_a <= ~pin_a;
    end else
      cnt <= cnt + 4'h1;
  end
endmodule

// ### bench/testbench.sv
// Self-checking bench for the oscillator select block
`timescale 1ns/1ps
`include "sos_params.svh"
module testbench;
  logic clk, resetn, rd_en, wr_en, wait_n, filt, pin_a, pin_b, a_out, a_oe, b_out, b_oe;
  logic g0_out, g0_oe, g1_out, g1_oe, sys_t, fast_t, wdt_t, fast_run, osc_a, osc_b;
  logic [3:0] addr, be, half;
  logic [1:0] src, freq, free;
  logic [31:0] wdata, rdata, last;
  logic [31:0] exp_q[$], msk_q[$];
  logic [1:0] free_exp[4] = '{2'b00, 2'b10, 2'b00, 2'b11};
  int n_fail, num_checks, cyc, ns, nf, nw, e;

  assign pin_a = a_oe ? a_out : osc_a;
  assign pin_b = b_oe ? b_out : osc_b;
  sos_osc_model osc (.clk(clk), .en(src != 2'd3 && (fast_run || src == 2'd2)),
    .half(half), .pin_a(osc_a), .pin_b(osc_b));
  sos_top uut (.clk(clk), .resetn(resetn), .avs_address(addr), .avs_read(rd_en),
    .avs_write(wr_en), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wait_n), .cfg_fast_src(src), .cfg_int_fast_freq(freq),
    .cfg_filter_off(filt), .clock_pin_a_in(pin_a), .clock_pin_a_out(a_out),
    .clock_pin_a_oe(a_oe), .clock_pin_b_in(pin_b), .clock_pin_b_out(b_out),
    .clock_pin_b_oe(b_oe), .port_c_bit0_out(g0_out), .port_c_bit0_oe(g0_oe),
    .port_c_bit1_out(g1_out), .port_c_bit1_oe(g1_oe), .port_c_free(free),
    .sys_tick(sys_t), .fast_tick(fast_t), .wdt_tick(wdt_t), .tbc_tick(),
    .fast_osc_running(fast_run));

  // =====================================================================
  // Clock, timeout and reporting
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Whole run is about 70k cycles; a hang ends the run here
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    num_checks++;
    if (seen !== expv) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expv);
    end
  endtask
  function automatic int near(int a, int x, int t);
    return (a >= x - t && a <= x + t) ? x : a;
  endfunction

  // =====================================================================
  // Bus master: request held until waitrequest is sampled low
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] b);
    addr <= a;
    wdata <= d;
    be <= b;
    if (w) wr_en <= 1'b1;
    else rd_en <= 1'b1;
    @(posedge clk);
    while (wait_n !== 1'b0) @(posedge clk);
    last = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic [31:0] m);
    exp_q.push_back(x);
    msk_q.push_back(m);
    bus(a, 1'b0, 32'h0, 4'hF);
  endtask
  // Monitor: every read answer is matched to the oldest note
  always @(posedge clk) begin
    if (rd_en && wait_n === 1'b0 && exp_q.size() > 0)
      check(rdata & msk_q.pop_front(), exp_q.pop_front());
  end
  task automatic wait_idle;
    for (int k = 0; k < 1500; k++) begin
      rd(`SOS_OFS_STATUS, 32'h0, 32'h0);
      if (last[4] === 1'b0) break;
    end
  endtask
  task automatic count(input int w);
    ns = 0;
    nf = 0;
    nw = 0;
    repeat (w) begin
      @(posedge clk);
      ns += int'(sys_t === 1'b1);
      nf += int'(fast_t === 1'b1);
      nw += int'(wdt_t === 1'b1);
    end
  endtask
  function automatic int fexp(int w);
    int hz[4] = '{`SOS_FAST_910K_HZ, `SOS_FAST_2M_HZ, `SOS_FAST_4M_HZ, `SOS_FAST_8M_HZ};
    if (src == 2'd3) return int'(longint'(w) * hz[freq] / `SOS_CLK_HZ);
    return w / (2 * int'(half));
  endfunction
  task automatic rst(input logic [1:0] s);
    resetn <= 1'b0;
    src <= s;
    freq <= 2'($urandom);
    filt <= 1'($urandom);
    half <= 4'(3 + $urandom % 6);
    {g0_out, g0_oe, g1_out, g1_oe} <= 4'($urandom);
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // =====================================================================
  // Main sequence: each fast source with a full divider sweep
  initial begin
    {resetn, rd_en, wr_en, filt, g0_out, g0_oe, g1_out, g1_oe} = 8'h00;
    {addr, be, half, src, freq, wdata} = 48'h0;
    void'($urandom(32'h39deac7d));
    for (int s = 0; s < 4; s++) begin
      rst(2'(s));
      rd(`SOS_OFS_CONFIG, {27'h0, filt, freq, src}, 32'hFF);
      rd(`SOS_OFS_MODE, 32'h01, 32'hFF);
      check({30'h0, free}, {30'h0, free_exp[s]});
      // Pin b is the crystal feedback, floats for an outside clock, else follows the port
      check({31'h0, b_oe}, {31'h0, s == 0 || (s != 2 && g1_oe)});
      count(2000);
      e = fexp(2000);
      check(32'(near(nf, e, 2)), 32'(e));
      check(32'(near(ns, e, 2)), 32'(e));
      for (int d = 7; d >= 0; d--) begin
        bus(`SOS_OFS_MODE, 1'b1, {24'h0, 3'(d), 5'h0}, 4'h1);
        wait_idle();
        if (d >= 2) rd(`SOS_OFS_STATUS, {27'h1, 1'b0, 3'(8 - d), 1'b0}, 32'h2F);
        else rd(`SOS_OFS_STATUS, 32'h01, 32'h21);
        count(1300);
        e = fexp(1300) >> (d >= 2 ? 8 - d : 0);
        if (d >= 2) check(32'(near(ns, e, 2)), 32'(e));
        else begin
          check(32'(nf), 32'h0);
          check(32'(near(ns, 1, 1)), 32'h1);
          check(32'(near(nw, 1, 1)), 32'h1);
        end
      end
      bus(`SOS_OFS_MODE, 1'b1, 32'h01, 4'h1);
      wait_idle();
      rd(`SOS_OFS_STATUS, 32'h20, 32'h2F);
      $display("test source %0d done", s);
    end
    // Register map edges: unused bits, lane enable, read-only and unmapped places
    bus(`SOS_OFS_MODE, 1'b1, 32'hFF, 4'h1);
    wait_idle();
    rd(`SOS_OFS_MODE, 32'hE1, 32'hFFFFFFFF);
    bus(`SOS_OFS_MODE, 1'b1, 32'h00, 4'h0);
    bus(`SOS_OFS_CONFIG, 1'b1, 32'h00, 4'hF);
    bus(4'hC, 1'b1, 32'hFF, 4'hF);
    rd(`SOS_OFS_MODE, 32'hE1, 32'hFFFFFFFF);
    rd(`SOS_OFS_CONFIG, {27'h0, filt, freq, src}, 32'hFFFFFFFF);
    rd(4'hC, 32'h0, 32'hFFFFFFFF);
    $display("test register map done");
    test_done();
  end
endmodule
